/* hdl/keypad_editor_pkg.sv */
// Constants and carrier types of the keypad digit value editor.
package keypad_editor_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int DEBOUNCE_MS = 8;
    localparam int LONG_PRESS_MS = 1000;
    localparam int EDIT_BLINK_MS = 500;
    localparam int FLASH_MS = 250;
    localparam int FLASH_PHASES = 6;
    localparam int DWELL_STEP_MS = 10;

    // Register byte addresses
    localparam logic [7:0] CTRL_A = 8'h00;
    localparam logic [7:0] OPEN_A = 8'h04;
    localparam logic [7:0] PVAL_LO_A = 8'h08;
    localparam logic [7:0] PVAL_HI_A = 8'h0C;
    localparam logic [7:0] PMIN_A = 8'h10;
    localparam logic [7:0] PMAX_A = 8'h14;
    localparam logic [7:0] STATUS_A = 8'h18;
    localparam logic [7:0] EXEC_A = 8'h1C;
    localparam logic [7:0] EDIT_A = 8'h20;

    // Field positions
    localparam int CTRL_FLD_LSB = 0;
    localparam int CTRL_ENT_LSB = 4;
    localparam int CTRL_REL_BIT = 6;
    localparam int CTRL_DP_LSB = 8;
    localparam int ST_IDX_LSB = 0;
    localparam int ST_EDIT_BIT = 4;
    localparam int ST_FLASH_BIT = 5;
    localparam int ST_REJECT_BIT = 6;
    localparam int ST_RUN_BIT = 7;
    localparam int ST_INPOS_BIT = 8;
    localparam int KEY_BACK = 0;
    localparam int KEY_SHIFT = 1;
    localparam int KEY_DOWN = 2;
    localparam int KEY_UP = 3;

    // Digit layout and ranges
    localparam int DIGITS_MAX = 10;
    localparam int ENTRIES = 4;
    localparam logic [3:0] HALF_DIGITS = 4'h5;
    localparam logic [3:0] LONG_MIN_DIGITS = 4'h7;
    localparam logic [3:0] NDIG_MAX = 4'hA;
    localparam logic [3:0] NDIG_HEX = 4'h2;
    localparam logic [3:0] NDIG_TARGET = 4'h7;
    localparam logic [3:0] NDIG_SPEED = 4'h6;
    localparam logic [3:0] NDIG_DWELL = 4'h5;
    localparam logic [3:0] DEC_MAX = 4'h9;
    localparam logic [3:0] HEX_MAX = 4'hF;
    localparam logic [33:0] TARGET_MAX = 34'h1E8480;
    localparam logic [33:0] SPEED_MIN = 34'h1;
    localparam logic [33:0] SPEED_MAX = 34'h927C0;
    localparam logic [33:0] DWELL_MAX = 34'hFFFF;
    localparam logic [7:0] AUX_RESET = 8'hFF;
    localparam logic [31:0] PMAX_RESET = 32'hFFFFFFFF;

    typedef enum logic [2:0] {
        FLD_PARAM, FLD_STATUS, FLD_TARGET, FLD_SPEED, FLD_DWELL, FLD_AUX
    } field_t;
    typedef enum logic [1:0] {ED_IDLE, ED_EDIT, ED_FLASH} ed_state_t;
    typedef enum logic [1:0] {PFX_NONE, PFX_HIGH, PFX_LOW} prefix_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic up;
        logic down;
        logic shift;
        logic back_out_key;
    } key_t;

    typedef struct packed {
        logic [7:0] status;
        logic neg;
        logic [27:0] target;
        logic [23:0] speed;
        logic [19:0] dwell;
        logic [7:0] aux;
    } entry_t;

    typedef struct packed {
        logic [39:0] digits;
        logic [9:0] lit;
        prefix_t prefix;
        logic neg;
        logic reject_indication;
        logic editing;
        logic [2:0] dwell_timer_decimal_place;
    } disp_t;

    typedef struct packed {
        logic start;
        logic [27:0] target;
        logic neg;
        logic relative;
        logic [7:0] aux_code;
        logic in_position_output;
    } move_t;

    typedef struct packed {
        logic [16:0] tick_cnt;
        logic [3:0][3:0] db_cnt;
        logic [3:0] key_st;
        logic [3:0] key_prev;
        logic [9:0] hold_ms;
        logic [8:0] blink_ms;
        logic blink_on;
        ed_state_t mode;
        logic [7:0] flash_ms;
        logic [2:0] flash_n;
        logic [39:0] buf_d;
        logic buf_neg;
        logic [3:0] idx;
        logic [3:0] ndig;
        field_t fld;
        logic [1:0] ent;
        logic reject;
        field_t fld_sel;
        logic [1:0] ent_sel;
        logic rel_mode;
        logic [2:0] dp_pos;
        logic [39:0] pval;
        logic [31:0] pmin;
        logic [31:0] pmax;
        entry_t [ENTRIES-1:0] tbl;
        logic running;
        logic [15:0] dwell_left;
        logic [3:0] dwell_ms;
        logic [31:0] rdata;
        disp_t disp;
        move_t move;
    } state_t;

endpackage

/* hdl/keypad_digit_value_editor.sv */
// Keypad digit-by-digit value editor with positioning table.
module keypad_digit_value_editor
    import keypad_editor_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS,
    parameter bit HAS_POSITIONING = 1'b1
) (
    // Clock and reset
    input logic core_clk,
    input logic reset,
    // Register port
    input bus_req_t bus,
    output logic [31:0] rdata,
    // Keypad and motion feedback
    input key_t keys,
    input logic at_target,
    // Display and positioning outputs
    output disp_t disp,
    output move_t move
);

    state_t st_r;
    state_t st_nxt;
    logic tick, long_ev, short_ev, sgn, long_val, ok, open_w, exec_w;
    logic [3:0] kv, press, rel, top, dig, dmax;
    logic [33:0] val;
    logic [39:0] sel_mask;
    entry_t ent_v;

    function automatic logic [33:0] bcd2bin(input logic [39:0] b);
        logic [33:0] acc;
        acc = '0;
        for (int i = DIGITS_MAX - 1; i >= 0; i--) begin
            acc = 34'(acc * 34'hA) + 34'(b[i*4 +: 4]);
        end
        return acc;
    endfunction

    assign rdata = st_r.rdata;
    assign disp = st_r.disp;
    assign move = st_r.move;

    always_comb begin
        st_nxt = st_r;
        kv = keys;
        tick = st_r.tick_cnt == 17'(TICK_CYCLES - 1);
        st_nxt.tick_cnt = tick ? '0 : st_r.tick_cnt + 17'h1;
        st_nxt.move.start = 1'b0;
        st_nxt.rdata = '0;
        // Debounce: a level must hold for several ms ticks
        for (int k = 0; k < 4; k++) begin
            if (kv[k] == st_r.key_st[k]) begin
                st_nxt.db_cnt[k] = '0;
            end else if (tick) begin
                if (st_r.db_cnt[k] == 4'(DEBOUNCE_MS - 1)) begin
                    st_nxt.key_st[k] = kv[k];
                    st_nxt.db_cnt[k] = '0;
                end else begin
                    st_nxt.db_cnt[k] = st_r.db_cnt[k] + 4'h1;
                end
            end
        end
        st_nxt.key_prev = st_r.key_st;
        press = st_r.key_st & ~st_r.key_prev;
        rel = ~st_r.key_st & st_r.key_prev;
        // Hold time saturates, so the commit fires once per hold
        if (!st_r.key_st[KEY_SHIFT]) begin
            st_nxt.hold_ms = '0;
        end else if (tick && st_r.hold_ms != 10'(LONG_PRESS_MS)) begin
            st_nxt.hold_ms = st_r.hold_ms + 10'h1;
        end
        long_ev = st_r.key_st[KEY_SHIFT] && tick &&
                  st_r.hold_ms == 10'(LONG_PRESS_MS - 1);
        short_ev = rel[KEY_SHIFT] && st_r.hold_ms != 10'(LONG_PRESS_MS);
        if (tick) begin
            if (st_r.blink_ms == 9'(EDIT_BLINK_MS - 1)) begin
                st_nxt.blink_ms = '0;
                st_nxt.blink_on = !st_r.blink_on;
            end else begin
                st_nxt.blink_ms = st_r.blink_ms + 9'h1;
            end
        end
        sgn = st_r.fld == FLD_TARGET;
        long_val = st_r.ndig >= LONG_MIN_DIGITS;
        top = sgn ? st_r.ndig : st_r.ndig - 4'h1;
        dig = st_r.buf_d[st_r.idx*4 +: 4];
        dmax = (st_r.fld == FLD_STATUS || st_r.fld == FLD_AUX) ?
               HEX_MAX : DEC_MAX;
        sel_mask = 40'hF << (st_r.idx * 4);
        val = bcd2bin(st_r.buf_d);
        unique case (st_r.fld)
            FLD_PARAM: ok = val >= 34'(st_r.pmin) &&
                            val <= 34'(st_r.pmax);
            FLD_TARGET: ok = val <= TARGET_MAX;
            FLD_SPEED: ok = val >= SPEED_MIN && val <= SPEED_MAX;
            FLD_DWELL: ok = val <= DWELL_MAX;
            default: ok = 1'b1;
        endcase
        if (|press) begin
            st_nxt.reject = 1'b0;
        end
        unique case (st_r.mode)
            ED_IDLE: begin
            end
            ED_EDIT: begin
                if (press[KEY_BACK]) begin
                    st_nxt.mode = ED_IDLE;
                end else if (long_ev) begin
                    if (!ok) begin
                        st_nxt.reject = 1'b1;
                    end else begin
                        st_nxt.mode = ED_FLASH;
                        st_nxt.flash_ms = '0;
                        st_nxt.flash_n = '0;
                        unique case (st_r.fld)
                            FLD_PARAM: st_nxt.pval = st_r.buf_d;
                            FLD_STATUS:
                                st_nxt.tbl[st_r.ent].status = st_r.buf_d[7:0];
                            FLD_TARGET: begin
                                st_nxt.tbl[st_r.ent].target = st_r.buf_d[27:0];
                                st_nxt.tbl[st_r.ent].neg = st_r.buf_neg;
                            end
                            FLD_SPEED:
                                st_nxt.tbl[st_r.ent].speed = st_r.buf_d[23:0];
                            FLD_DWELL:
                                st_nxt.tbl[st_r.ent].dwell = st_r.buf_d[19:0];
                            default:
                                st_nxt.tbl[st_r.ent].aux = st_r.buf_d[7:0];
                        endcase
                    end
                end else if (short_ev) begin
                    st_nxt.idx = st_r.idx == top ? 4'h0 : st_r.idx + 4'h1;
                end else if (press[KEY_UP] || press[KEY_DOWN]) begin
                    if (sgn && st_r.idx == st_r.ndig) begin
                        st_nxt.buf_neg = !st_r.buf_neg;
                    end else if (press[KEY_UP]) begin
                        st_nxt.buf_d[st_r.idx*4 +: 4] =
                            dig == dmax ? 4'h0 : dig + 4'h1;
                    end else begin
                        st_nxt.buf_d[st_r.idx*4 +: 4] =
                            dig == 4'h0 ? dmax : dig - 4'h1;
                    end
                end
            end
            ED_FLASH: begin
                if (tick) begin
                    if (st_r.flash_ms == 8'(FLASH_MS - 1)) begin
                        st_nxt.flash_ms = '0;
                        st_nxt.flash_n = st_r.flash_n + 3'h1;
                        if (st_r.flash_n == 3'(FLASH_PHASES - 1)) begin
                            st_nxt.mode = ED_IDLE;
                        end
                    end else begin
                        st_nxt.flash_ms = st_r.flash_ms + 8'h1;
                    end
                end
            end
        endcase
        // Positioning run: dwell counts once the motor is at target
        if (st_r.running && at_target) begin
            if (st_r.dwell_left == '0) begin
                st_nxt.move.in_position_output = 1'b1;
                st_nxt.running = 1'b0;
            end else if (tick) begin
                if (st_r.dwell_ms == 4'(DWELL_STEP_MS - 1)) begin
                    st_nxt.dwell_ms = '0;
                    st_nxt.dwell_left = st_r.dwell_left - 16'h1;
                end else begin
                    st_nxt.dwell_ms = st_r.dwell_ms + 4'h1;
                end
            end
        end
        // Register port
        open_w = bus.wr && bus.addr == OPEN_A;
        exec_w = bus.wr && bus.addr == EXEC_A;
        ent_v = st_r.tbl[st_r.ent_sel];
        if (bus.wr) begin
            unique case (bus.addr)
                CTRL_A: begin
                    st_nxt.fld_sel = field_t'(bus.wdata[CTRL_FLD_LSB +: 3]);
                    st_nxt.ent_sel = bus.wdata[CTRL_ENT_LSB +: 2];
                    st_nxt.rel_mode = bus.wdata[CTRL_REL_BIT];
                    st_nxt.dp_pos = bus.wdata[CTRL_DP_LSB +: 3];
                end
                PVAL_LO_A: st_nxt.pval[31:0] = bus.wdata;
                PVAL_HI_A: st_nxt.pval[39:32] = bus.wdata[7:0];
                PMIN_A: st_nxt.pmin = bus.wdata;
                PMAX_A: st_nxt.pmax = bus.wdata;
                default: begin
                end
            endcase
        end
        if (open_w) begin
            st_nxt.fld = st_r.fld_sel;
            st_nxt.ent = st_r.ent_sel;
            st_nxt.reject = 1'b0;
            st_nxt.blink_on = 1'b1;
            st_nxt.blink_ms = '0;
            st_nxt.buf_neg = 1'b0;
            st_nxt.mode = ED_EDIT;
            unique case (st_r.fld_sel)
                FLD_PARAM: begin
                    st_nxt.buf_d = st_r.pval;
                    st_nxt.ndig = (bus.wdata[3:0] == 4'h0 ||
                                   bus.wdata[3:0] > NDIG_MAX) ?
                                  NDIG_MAX : bus.wdata[3:0];
                end
                FLD_TARGET: begin
                    st_nxt.buf_d = {12'h0, ent_v.target};
                    st_nxt.buf_neg = ent_v.neg;
                    st_nxt.ndig = NDIG_TARGET;
                end
                FLD_SPEED: begin
                    st_nxt.buf_d = {16'h0, ent_v.speed};
                    st_nxt.ndig = NDIG_SPEED;
                end
                FLD_DWELL: begin
                    st_nxt.buf_d = {20'h0, ent_v.dwell};
                    st_nxt.ndig = NDIG_DWELL;
                end
                FLD_STATUS: begin
                    st_nxt.buf_d = {32'h0, ent_v.status};
                    st_nxt.ndig = NDIG_HEX;
                end
                default: begin
                    st_nxt.buf_d = {32'h0, ent_v.aux};
                    st_nxt.ndig = NDIG_HEX;
                end
            endcase
            // Long values open on the high half, units of that half first
            st_nxt.idx = st_nxt.ndig >= LONG_MIN_DIGITS ?
                         HALF_DIGITS : 4'h0;
            if (!HAS_POSITIONING && st_r.fld_sel != FLD_PARAM) begin
                st_nxt.mode = ED_IDLE;
                st_nxt.reject = 1'b1;
            end
        end
        if (exec_w && HAS_POSITIONING) begin
            st_nxt.move.start = 1'b1;
            st_nxt.move.target = ent_v.target;
            st_nxt.move.neg = ent_v.neg;
            st_nxt.move.relative = st_r.rel_mode;
            st_nxt.move.aux_code = ent_v.aux;
            st_nxt.move.in_position_output = 1'b0;
            st_nxt.running = 1'b1;
            st_nxt.dwell_ms = '0;
            st_nxt.dwell_left = 16'(bcd2bin({20'h0, ent_v.dwell}));
        end
        if (bus.rd) begin
            unique case (bus.addr)
                CTRL_A: begin
                    st_nxt.rdata[CTRL_FLD_LSB +: 3] = st_r.fld_sel;
                    st_nxt.rdata[CTRL_ENT_LSB +: 2] = st_r.ent_sel;
                    st_nxt.rdata[CTRL_REL_BIT] = st_r.rel_mode;
                    st_nxt.rdata[CTRL_DP_LSB +: 3] = st_r.dp_pos;
                end
                PVAL_LO_A: st_nxt.rdata = st_r.pval[31:0];
                PVAL_HI_A: st_nxt.rdata[7:0] = st_r.pval[39:32];
                PMIN_A: st_nxt.rdata = st_r.pmin;
                PMAX_A: st_nxt.rdata = st_r.pmax;
                STATUS_A: begin
                    st_nxt.rdata[ST_IDX_LSB +: 4] = st_r.idx;
                    st_nxt.rdata[ST_EDIT_BIT] = st_r.mode == ED_EDIT;
                    st_nxt.rdata[ST_FLASH_BIT] = st_r.mode == ED_FLASH;
                    st_nxt.rdata[ST_REJECT_BIT] = st_r.reject;
                    st_nxt.rdata[ST_RUN_BIT] = st_r.running;
                    st_nxt.rdata[ST_INPOS_BIT] = st_r.move.in_position_output;
                end
                EDIT_A: st_nxt.rdata = st_r.buf_d[31:0];
                default: begin
                end
            endcase
        end
        // Display image
        st_nxt.disp.digits = st_r.buf_d;
        st_nxt.disp.neg = st_r.buf_neg;
        st_nxt.disp.reject_indication = st_r.reject;
        st_nxt.disp.editing = st_r.mode == ED_EDIT;
        st_nxt.disp.dwell_timer_decimal_place = st_r.dp_pos;
        st_nxt.disp.lit = '1;
        if (st_r.mode == ED_EDIT && !st_r.blink_on && st_r.idx < st_r.ndig) begin
            st_nxt.disp.lit[st_r.idx] = 1'b0;
        end else if (st_r.mode == ED_FLASH && !st_r.flash_n[0]) begin
            st_nxt.disp.lit = '0;
        end
        if (!long_val) begin
            st_nxt.disp.prefix = PFX_NONE;
        end else begin
            st_nxt.disp.prefix = st_r.idx >= HALF_DIGITS ?
                                 PFX_HIGH : PFX_LOW;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r <= '0;
            st_r.pmax <= PMAX_RESET;
            for (int i = 0; i < ENTRIES; i++) begin
                st_r.tbl[i].aux <= AUX_RESET;
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_flash_last;
        st_r.mode == ED_FLASH ##1 st_r.mode == ED_IDLE && !$past(open_w);
    endsequence

    property p_open_units;
        open_w && HAS_POSITIONING |=> st_r.mode == ED_EDIT &&
            st_r.idx == (st_r.ndig >= LONG_MIN_DIGITS ? HALF_DIGITS : 4'h0);
    endproperty
    a_open_units: assert property (p_open_units)
        else $error("edit position not at units after open");

    property p_digit_only;
        st_r.mode == ED_EDIT && !open_w && !press[KEY_BACK] && !long_ev &&
            !short_ev && press[KEY_UP] && st_r.idx < st_r.ndig
        |=> (st_r.buf_d & ~$past(sel_mask)) == $past(st_r.buf_d & ~sel_mask);
    endproperty
    a_digit_only: assert property (p_digit_only)
        else $error("up key touched a neighbouring digit");

    property p_back_out;
        st_r.mode == ED_EDIT && press[KEY_BACK] && !open_w |=>
            st_r.mode == ED_IDLE;
    endproperty
    a_back_out: assert property (p_back_out)
        else $error("back-out key did not leave editing");

    property p_commit;
        st_r.mode == ED_EDIT && long_ev && !press[KEY_BACK] && !open_w |=>
            (st_r.mode == ED_FLASH) != st_r.reject;
    endproperty
    a_commit: assert property (p_commit)
        else $error("long press did not commit or reject");

    property p_flash_count;
        s_flash_last |-> $past(st_r.flash_n, 2) == 3'(FLASH_PHASES - 1);
    endproperty
    a_flash_count: assert property (p_flash_count)
        else $error("commit flash ended after the wrong count");

    property p_reject_keeps;
        $rose(st_r.reject) |-> $stable(st_r.pval);
    endproperty
    a_reject_keeps: assert property (p_reject_keeps)
        else $error("rejected value reached the parameter");

    property p_in_position;
        $rose(st_r.move.in_position_output) |->
            $past(at_target) && $past(st_r.dwell_left) == 16'h0;
    endproperty
    a_in_position: assert property (p_in_position)
        else $error("in-position before dwell elapsed");

    property p_aux_init;
        $fell(reset) |-> st_r.tbl[ENTRIES-1].aux == AUX_RESET;
    endproperty
    a_aux_init: assert property (p_aux_init)
        else $error("aux code not FF after reset");

    property p_blink_rate;
        $changed(st_r.blink_on) && !$past(open_w) |->
            $past(st_r.blink_ms) == 9'(EDIT_BLINK_MS - 1) && $past(tick);
    endproperty
    a_blink_rate: assert property (p_blink_rate)
        else $error("edit blink toggled off its interval");

endmodule // keypad_digit_value_editor

/* tb/keypad_operator.sv */
// Operator model pressing front-panel keys for set spans of time.
module keypad_operator
    import keypad_editor_pkg::*;
#(
    parameter int TICK_CYCLES = 4
) (
    // Clock
    input logic core_clk,
    // Keys
    output key_t keys
);
    timeunit 1ns;
    timeprecision 1ps;

    initial keys = '0;

    // Hold one key for ms, then stay off past debounce
    task automatic press(input int k, input int ms);
        @(posedge core_clk);
        keys[k] <= 1'b1;
        repeat (ms * TICK_CYCLES) @(posedge core_clk);
        keys[k] <= 1'b0;
        repeat (12 * TICK_CYCLES) @(posedge core_clk);
    endtask
endmodule // keypad_operator

/* tb/keypad_digit_value_editor_tb.sv */
// Self-checking bench of the keypad digit value editor.
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module keypad_digit_value_editor_tb
    import keypad_editor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, reset, at_target;
    bus_req_t bus;
    logic [31:0] rdata, v;
    key_t keys;
    disp_t disp, disp_b;
    move_t move;
    int errors = 0;
    int total_checks = 0;

    keypad_digit_value_editor #(.TICK_CYCLES(4), .HAS_POSITIONING(1'b1))
    dut_u (.core_clk(core_clk), .reset(reset), .bus(bus), .rdata(rdata),
        .keys(keys), .at_target(at_target), .disp(disp), .move(move));
    keypad_operator #(.TICK_CYCLES(4)) op_u (.core_clk(core_clk),
        .keys(keys));
    // Variant without the positioning function
    keypad_digit_value_editor #(.TICK_CYCLES(4), .HAS_POSITIONING(1'b0))
    bare_u (.core_clk(core_clk), .reset(reset), .bus(bus), .rdata(),
        .keys(keys), .at_target(at_target), .disp(disp_b), .move());

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic t_open_edit();
        wr(CTRL_A, 32'h0);
        wr(PVAL_LO_A, 32'h0090_0000);
        wr(OPEN_A, 32'h7);
        rd(STATUS_A, v); `CHK(v, 32'h15)
        `CHK(disp.prefix, PFX_HIGH)
        `CHK(disp.editing, 1'b1)
        op_u.press(KEY_UP, 12);
        rd(EDIT_A, v); `CHK(v, 32'h0)
        op_u.press(KEY_DOWN, 12);
        rd(EDIT_A, v); `CHK(v, 32'h0090_0000)
        `CHK(disp.digits, 40'h00_0090_0000)
        op_u.press(KEY_SHIFT, 12);
        rd(STATUS_A, v); `CHK(v, 32'h16)
        $display("test open_edit done");
    endtask

    task automatic t_commit();
        wr(PMAX_A, 32'h10);
        op_u.press(KEY_SHIFT, 1100);
        rd(STATUS_A, v); `CHK(v, 32'h56)
        `CHK(disp.reject_indication, 1'b1)
        rd(PVAL_LO_A, v); `CHK(v, 32'h0090_0000)
        wr(PMAX_A, 32'hFFFF_FFFF);
        wr(PVAL_LO_A, 32'h0);
        op_u.press(KEY_SHIFT, 1100);
        rd(STATUS_A, v); `CHK(v[6:4], 3'h2)
        `CHK(disp.lit, 10'h0)
        repeat (6000) @(posedge core_clk);
        rd(STATUS_A, v); `CHK(v[6:4], 3'h0)
        rd(PVAL_LO_A, v); `CHK(v, 32'h0090_0000)
        $display("test commit done");
    endtask

    task automatic t_position();
        wr(CTRL_A, 32'h0000_0562);
        wr(OPEN_A, 32'h0);
        repeat (2) @(posedge core_clk);
        #1 `CHK({disp_b.reject_indication, disp_b.editing}, 2'h2)
        op_u.press(KEY_UP, 12);
        op_u.press(KEY_SHIFT, 12);
        op_u.press(KEY_SHIFT, 12);
        op_u.press(KEY_UP, 12);
        rd(STATUS_A, v); `CHK(v, 32'h17)
        rd(EDIT_A, v); `CHK(v, 32'h0010_0000)
        `CHK(disp.neg, 1'b1)
        `CHK(disp.dwell_timer_decimal_place, 3'h5)
        op_u.press(KEY_SHIFT, 1100);
        wr(CTRL_A, 32'h0000_0564);
        wr(OPEN_A, 32'h0);
        op_u.press(KEY_UP, 12);
        op_u.press(KEY_SHIFT, 1100);
        rd(STATUS_A, v); `CHK(v[6:4], 3'h2)
        wr(EXEC_A, 32'h0);
        #1 `CHK(move.start, 1'b1)
        `CHK(move.target, 28'h010_0000)
        `CHK({move.neg, move.relative}, 2'h3)
        `CHK(move.aux_code, 8'hFF)
        @(posedge core_clk);
        at_target <= 1'b1;
        repeat (20) @(posedge core_clk);
        #1 `CHK(move.in_position_output, 1'b0)
        repeat (40) @(posedge core_clk);
        rd(STATUS_A, v); `CHK(v[8:7], 2'h2)
        `CHK(move.in_position_output, 1'b1)
        $display("test position done");
    endtask

    task automatic t_aux_back();
        wr(CTRL_A, 32'h5);
        wr(OPEN_A, 32'h0);
        rd(EDIT_A, v); `CHK(v, 32'hFF)
        rd(STATUS_A, v); `CHK(v[4], 1'b1)
        op_u.press(KEY_BACK, 12);
        rd(STATUS_A, v); `CHK(v[4], 1'b0)
        rd(8'h40, v); `CHK(v, 32'h0)
        $display("test aux_back done");
    endtask

    initial begin
        reset = 1'b1;
        bus = '0;
        at_target = 1'b0;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        rd(STATUS_A, v); `CHK(v, 32'h0)
        t_open_edit();
        t_commit();
        t_position();
        t_aux_back();
        summarize();
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        errors++;
        summarize();
    end
endmodule // keypad_digit_value_editor_tb
